// ---- hw/mne_exec.v ----
// Contract
// - Multiply-literal multiplies working register by unsigned 8-bit literal
// - Full 16-bit product goes to product high and low bytes
// - Multiply-literal leaves working register unchanged
// - Multiply-literal changes no status flag, even on zero product
// - Multiply-register multiplies working register by memory byte, flags kept
// - Negate writes inverse plus one back to same memory location
// - Negate updates N, OV, C, DC and Z flags
// - Access bit 0 selects access bank, bank register ignored
// - Access bit 1 forms address from bank register and field
// - 8-bit field picks byte in 256-byte bank; bank gives upper bits
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "mne_exec_defines.vh"
module mne_exec #(
  parameter MEM_DEPTH = 4096
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // State views
  output reg [7:0] working_register,
  output reg [7:0] product_high_byte,
  output reg [7:0] product_low_byte,
  output reg [4:0] status_flags,
  output reg done_pulse
);
  // Data memory: no reset, software loads it through the data window
  reg [7:0] mem [0:MEM_DEPTH-1];
  reg [3:0] bank_select_register;
  reg [11:0] mem_addr_reg;
  // Next values of the software-visible state
  reg [7:0] working_next;
  reg [15:0] product_next;
  reg [4:0] status_next;
  reg [3:0] bank_next;
  reg [11:0] mem_addr_next;
  // Bus response, prepared in the setup cycle
  reg [31:0] read_next;
  reg err_next;
  reg [11:0] eff_addr;
  reg [4:0] neg_flags;
  wire [15:0] prod_lit;
  wire [15:0] prod_reg;
  // Bus phases
  wire setup_phase = psel & ~penable;
  wire rd_setup = setup_phase & ~pwrite;
  // Writes land only at the edge where the access completes
  wire access_done = psel & penable & pready;
  wire wr_en = access_done & pwrite;
  // Address decode
  wire sel_instr = (paddr == `ADDR_INSTR);
  wire sel_working = (paddr == `ADDR_WORKING);
  wire sel_bank = (paddr == `ADDR_BANK);
  wire sel_product = (paddr == `ADDR_PRODUCT);
  wire sel_status = (paddr == `ADDR_STATUS);
  wire sel_mem_addr = (paddr == `ADDR_MEM_ADDR);
  wire sel_mem_data = (paddr == `ADDR_MEM_DATA);
  wire sel_mapped = sel_instr | sel_working | sel_bank | sel_product |
    sel_status | sel_mem_addr | sel_mem_data;
  wire instr_wr = wr_en & sel_instr;
  // Instruction word and its fields
  wire [15:0] instr = pwdata[15:0];
  wire [7:0] field = instr[7:0];
  wire access_bit = instr[8];
  wire multiply_literal_op = (instr[15:8] == `OPC_MUL_LIT);
  wire multiply_register_op = (instr[15:9] == `OPC_MUL_REG);
  wire negate_register_op = (instr[15:9] == `OPC_NEGATE);
  wire is_nop = (instr == `OPC_NOP_ZERO) || (instr[15:12] == `OPC_NOP_HIGH);
  wire known_op = multiply_literal_op | multiply_register_op | negate_register_op | is_nop;
  always @* begin
    if (!access_bit) begin
      if (field < `ACCESS_SPLIT)
        eff_addr = {4'h0, field};
      else
        eff_addr = {`ACCESS_HIGH_BANK, field};
    end else begin
      eff_addr = {bank_select_register, field};
    end
  end
  wire [7:0] operand = mem[eff_addr];
  wire [7:0] window_byte = mem[mem_addr_reg];
  unsigned_mult #(
    .WIDTH(8)
  ) u_mul_lit (
    .op_a(working_register),
    .op_b(field),
    .product(prod_lit)
  );
  unsigned_mult #(
    .WIDTH(8)
  ) u_mul_reg (
    .op_a(working_register),
    .op_b(operand),
    .product(prod_reg)
  );
  wire [8:0] neg_sum = {1'b0, ~operand} + 9'h001;
  wire [4:0] neg_low = {1'b0, ~operand[3:0]} + 5'h01;
  wire [7:0] neg_res = neg_sum[7:0];
  // Overflow only when the most negative byte negates to itself
  wire neg_ov = operand[7] & neg_res[7];
  always @* begin
    neg_flags = 5'h00;
    neg_flags[`FLAG_C] = neg_sum[8];
    neg_flags[`FLAG_DC] = neg_low[4];
    neg_flags[`FLAG_Z] = (neg_res == 8'h00);
    neg_flags[`FLAG_OV] = neg_ov;
    neg_flags[`FLAG_N] = neg_res[7];
  end
  // Instruction execution and register writes
  always @* begin
    working_next = working_register;
    product_next = {product_high_byte, product_low_byte};
    status_next = status_flags;
    bank_next = bank_select_register;
    mem_addr_next = mem_addr_reg;
    if (instr_wr) begin
      if (multiply_literal_op) begin
        product_next = prod_lit;
      end else if (multiply_register_op) begin
        product_next = prod_reg;
      end else if (negate_register_op) begin
        status_next = neg_flags;
      end
    end else if (wr_en) begin
      if (sel_working)
        working_next = pwdata[7:0];
      else if (sel_bank)
        bank_next = pwdata[3:0];
      else if (sel_product)
        product_next = pwdata[15:0];
      else if (sel_status)
        status_next = pwdata[4:0];
      else if (sel_mem_addr)
        mem_addr_next = pwdata[11:0];
    end
  end
  // Read mux; the instruction slot reads as zero
  always @* begin
    read_next = 32'h0000_0000;
    if (sel_working)
      read_next = {24'h00_0000, working_register};
    else if (sel_bank)
      read_next = {28'h000_0000, bank_select_register};
    else if (sel_product)
      read_next = {16'h0000, product_high_byte, product_low_byte};
    else if (sel_status)
      read_next = {27'h000_0000, status_flags};
    else if (sel_mem_addr)
      read_next = {20'h0_0000, mem_addr_reg};
    else if (sel_mem_data)
      read_next = {24'h00_0000, window_byte};
  end
  // Unmapped addresses and unknown instruction words are refused
  always @* begin
    err_next = 1'b0;
    if (setup_phase) begin
      if (!sel_mapped)
        err_next = 1'b1;
      else if (pwrite && sel_instr && !known_op)
        err_next = 1'b1;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_register <= `RST_WORKING;
      product_high_byte <= `RST_PRODUCT_HIGH;
      product_low_byte <= `RST_PRODUCT_LOW;
      status_flags <= `RST_STATUS;
      bank_select_register <= `RST_BANK;
      mem_addr_reg <= `RST_MEM_ADDR;
      done_pulse <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      working_register <= working_next;
      product_high_byte <= product_next[15:8];
      product_low_byte <= product_next[7:0];
      status_flags <= status_next;
      bank_select_register <= bank_next;
      mem_addr_reg <= mem_addr_next;
      done_pulse <= instr_wr;
      // Loaded at the setup edge so data and error stand with pready
      pready <= setup_phase;
      pslverr <= err_next;
      if (rd_setup)
        prdata <= read_next;
    end
  end
  always @(posedge pclk) begin
    if (instr_wr && negate_register_op)
      mem[eff_addr] <= neg_res;
    else if (wr_en && sel_mem_data)
      mem[mem_addr_reg] <= pwdata[7:0];
  end
endmodule

// Unsigned multiplier with full-width product
module unsigned_mult #(
  parameter WIDTH = 8
) (
  // Operands
  input wire [WIDTH-1:0] op_a,
  input wire [WIDTH-1:0] op_b,
  // Product
  output wire [2*WIDTH-1:0] product
);
  assign product = {{WIDTH{1'b0}}, op_a} * {{WIDTH{1'b0}}, op_b};
endmodule
`default_nettype wire

// ---- hw/mne_exec_defines.vh ----
`ifndef MNE_EXEC_DEFINES_VH
`define MNE_EXEC_DEFINES_VH
// APB register byte addresses
`define ADDR_INSTR 12'h000
`define ADDR_WORKING 12'h004
`define ADDR_BANK 12'h008
`define ADDR_PRODUCT 12'h00C
`define ADDR_STATUS 12'h010
`define ADDR_MEM_ADDR 12'h014
`define ADDR_MEM_DATA 12'h018
// Opcode patterns, upper bits of instruction word; OPC_NOP_ZERO is the whole word
`define OPC_MUL_LIT 8'h0D
`define OPC_MUL_REG 7'h01
`define OPC_NEGATE 7'h36
`define OPC_NOP_ZERO 16'h0000
`define OPC_NOP_HIGH 4'hF
// Status flag positions
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_N 4
// Access bank split: low half below this offset maps to bank 0
`define ACCESS_SPLIT 8'h80
`define ACCESS_HIGH_BANK 4'hF
// Reset values of the software-visible state
`define RST_WORKING 8'h00
`define RST_PRODUCT_HIGH 8'h00
`define RST_PRODUCT_LOW 8'h00
`define RST_STATUS 5'h00
`define RST_BANK 4'h0
`define RST_MEM_ADDR 12'h000
`endif

// ---- tb/mne_exec_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module mne_exec_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request and handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // State views
  input wire logic [7:0] working_register,
  input wire logic [7:0] product_high_byte,
  input wire logic [7:0] product_low_byte,
  input wire logic [4:0] status_flags,
  input wire logic done_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire iw = psel & penable & pready & pwrite & (paddr == 12'h000);
  wire [7:0] op = pwdata[15:8];
  wire ml = iw & (op == 8'h0D);
  wire mr = iw & (op[7:1] == 7'h01);
  wire ng = iw & (op[7:1] == 7'h36);
  wire np = iw & ((pwdata[15:0] == 16'h0000) | (op[7:4] == 4'hF));
  mul_lit_prod_a: assert property (ml |=> {product_high_byte, product_low_byte} ==
    {8'h00, $past(working_register)} * {8'h00, $past(pwdata[7:0])}) else $error("bad product");
  mul_lit_w_a: assert property (ml |=> $stable(working_register))
    else $error("working register moved");
  mul_lit_flag_a: assert property (ml |=> $stable(status_flags))
    else $error("flags moved on literal multiply");
  mul_reg_flag_a: assert property (mr |=> $stable(status_flags))
    else $error("flags moved on register multiply");
  mul_reg_w_a: assert property (mr |=> $stable(working_register))
    else $error("working register moved");
  neg_keep_a: assert property (ng |=> $stable({working_register, product_high_byte}))
    else $error("negate touched wrong register");
  nop_keep_a: assert property (np |=> $stable({working_register, product_high_byte,
    product_low_byte, status_flags})) else $error("no-op changed state");
  instr_done_a: assert property (iw |=> done_pulse ##1 !done_pulse)
    else $error("bad done pulse");
  neg_carry_a: assert property (ng |=> status_flags[0] == status_flags[2])
    else $error("negate carry and zero disagree");
  neg_ov_a: assert property (ng |=> !status_flags[3] || (status_flags[4] && status_flags[1]))
    else $error("negate overflow without the most negative byte");
endmodule
bind mne_exec mne_exec_chk u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .paddr(paddr),
  .pwdata(pwdata),
  .working_register(working_register),
  .product_high_byte(product_high_byte),
  .product_low_byte(product_low_byte),
  .status_flags(status_flags),
  .done_pulse(done_pulse)
);
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, done_pulse;
  logic [7:0] working_register, product_high_byte, product_low_byte;
  logic [4:0] status_flags;
  int n_fail = 0, checks_done = 0;
  // Entry: bit 28 write, bit 29 refused, bit 30 end of test; then address, data
  logic [31:0] t [53] = '{
    32'h1004_00E2, 32'h1000_0DC4, 32'h000C_AD08, 32'h0004_00E2,
    32'h4000_0001,
    32'h1008_0005, 32'h1014_0020, 32'h1018_003A, 32'h1000_6C20,
    32'h0018_00C6, 32'h0010_0010, 32'h4000_0002,
    32'h1014_0F90, 32'h1018_0010, 32'h1000_6C90, 32'h0018_00F0,
    32'h0010_0012, 32'h4000_0003,
    32'h1014_0520, 32'h1018_0000, 32'h1000_6D20, 32'h0010_0007,
    32'h4000_0004,
    32'h1014_0522, 32'h1018_0080, 32'h1000_6D22, 32'h0018_0080, 32'h0010_001A,
    32'h4000_0005,
    32'h1014_0521, 32'h1018_00B5, 32'h1004_00C4, 32'h1000_0321,
    32'h000C_8A94, 32'h0010_001A, 32'h1000_0220, 32'h000C_9798,
    32'h4000_0006,
    32'h1000_0D00, 32'h000C_0000, 32'h0010_001A, 32'h4000_0007,
    32'h100C_1234, 32'h1000_0000, 32'h1000_F123, 32'h000C_1234,
    32'h0010_001A, 32'h0004_00C4, 32'h4000_0008,
    32'h3000_5000, 32'h000C_1234, 32'h201C_0000, 32'h4000_0009};
  always #12.5 pclk = ~pclk;
  mne_exec uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .working_register(working_register),
    .product_high_byte(product_high_byte),
    .product_low_byte(product_low_byte),
    .status_flags(status_flags),
    .done_pulse(done_pulse)
  );
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task stp(input logic [31:0] e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= e[28];
    paddr <= e[27:16];
    pwdata <= {16'h0000, e[15:0]};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    psel <= 1'b0;
    penable <= 1'b0;
    checks_done++;
    // A hung access also lands here, as a mismatch
    if (pready !== 1'b1 || pslverr !== e[29] || (!e[28] && prdata !== {16'h0000, e[15:0]})) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, prdata, e[15:0]);
    end
    if (pready !== 1'b1) give_verdict;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (t[i]) begin
      if (t[i][30])
        $display("test %0d done", t[i][3:0]);
      else
        stp(t[i]);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
